// ---- src/thermal_map.svh ----
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: 50 MHz CORE_CLK, 32-bit AXI4-Lite register bus
// Notes: offsets are byte addresses, one aligned word per register
// Behaviour
// [RQ1] Each of the three motors picks one of four protection modes in its own field.
// [RQ2] Mode 0 does no overload monitoring and never raises the overheat alarm.
// [RQ3] Mode 1 uses a trip current that does not change with speed.
// [RQ4] Mode 3 (reset value) derates the trip current for shaft fans, mode 2 for separate fans.
// [RQ5] The thermal model is evaluated only in modes 1, 2 and 3.
// [RQ6] Every motor keeps its own thermal state, untouched by the others.
// [RQ7] Modelled heating moves toward the square of the measured current.
// [RQ8] The overheat alarm rises when the modelled trip time has run out.
// [RQ9] The overheat alarm cannot be cleared until a cooling delay of one time constant ends.
// [RQ10] Heating is readable as a percentage of the asymptotic level.
// [RQ11] With sensor protection on, the sensor alarm rises when the analog input exceeds the threshold.
// [RQ12] The sensor alarm clears only after the input drops 5% below its trip level.
// [RQ13] Monitoring begins only when current exceeds the programmable start level, 105% at reset.
// [RQ14] Software should set the time constant to 36 s per trip class (360, 720, 1080 s).
// [RQ15] The model updates at a fixed sampling interval with fixed-point arithmetic.
`ifndef THERMAL_MAP_SVH
`define THERMAL_MAP_SVH
`define CLK_HZ 50000000
`define SAMPLE_HZ 1024
`define SAMPLE_CYCLES (`CLK_HZ / `SAMPLE_HZ)
`define FRAC_BITS 10
`define OFS_CTRL 8'h00
`define OFS_START 8'h04
`define OFS_TAU 8'h08
`define OFS_THRESH 8'h0c
`define OFS_STATUS 8'h10
`define OFS_MASK 8'h14
`define OFS_HEAT1 8'h18
`define OFS_HEAT2 8'h1c
`define OFS_HEAT3 8'h20
`define CTRL_SENS_BIT 8
`define ST_SENS_BIT 3
`define RST_MODE 2'h3
`define RST_START 10'h069
`define RST_TAU 16'h0168
`define RST_THRESH 12'h800
`define KNEE_HI 10'h032
`define KNEE_LO 10'h019
`define HYST_DIV 12'h014
`define PCT_DIV 20'h00064
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- src/thermal_pkg.sv ----
// Purpose: types shared by the thermal protection design
// Assumes: nothing beyond the map header
// Notes: all module state is held in the packed structs below
package thermal_pkg;
	// model update sequencer
	typedef enum logic [1:0] {S_IDLE, S_READ, S_CALC} seq_e;
	// heat memory access
	typedef struct packed {
		logic we;
		logic [1:0] addr;
		logic [31:0] wdata;
	} mem_req_s;
	typedef struct packed {
		logic [3:0][31:0] word;
		logic [31:0] rdata;
	} mem_state_s;
	// whole state of the protection block
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_full;
		logic w_full;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [2:0][1:0] mode;
		logic sens_en;
		logic [9:0] start_cur;
		logic [15:0] tau;
		logic [11:0] thresh;
		logic [3:0] status;
		logic [3:0] mask;
		logic irq;
		logic ovh;
		logic sen;
		logic [2:0][9:0] pct;
		logic [2:0][15:0] cool;
		logic [11:0] sens_trip;
		logic [15:0] tick_cnt;
		logic [15:0] step_cnt;
		logic [9:0] sec_cnt;
		seq_e seq;
		logic [1:0] idx;
	} prot_state_s;
endpackage : thermal_pkg

// ---- src/heat_mem.sv ----
// Purpose: per-motor heat accumulator storage
// Assumes: one access per cycle, read data registered
// Notes: read returns the old word when the same address is written
`timescale 1ns/100ps
`default_nettype none
module heat_mem (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// access port
	input wire thermal_pkg::mem_req_s req,
	output logic [31:0] rdata
);
	thermal_pkg::mem_state_s m_q;
	thermal_pkg::mem_state_s m_d;

	// write and registered read
	always_comb begin
		m_d = m_q;
		if (req.we) begin
			m_d.word[req.addr] = req.wdata;
		end
		m_d.rdata = m_q.word[req.addr];
	end

	// state register, cleared so every motor starts cold
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			m_q <= '0;
		end else begin
			m_q <= m_d;
		end
	end

	assign rdata = m_q.rdata;
endmodule : heat_mem
`default_nettype wire

// ---- src/motor_thermal_protection.sv ----
// Purpose: motor overload thermal model and sensor alarm with AXI4-Lite registers
// Assumes: current and speed inputs in percent of rating, synchronous to CORE_CLK
// Notes: model steps every tau sample ticks, giving a time constant of tau seconds
`timescale 1ns/100ps
`default_nettype none
`include "thermal_map.svh"
module motor_thermal_protection #(
	parameter logic [15:0] SAMPLE_CYCLES = 16'(`SAMPLE_CYCLES)
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	// axi4-lite write address
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// axi4-lite write data
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// axi4-lite read address
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// axi4-lite read data
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// drive measurements
	input wire logic [9:0] MOTOR_CURRENT,
	input wire logic [9:0] MOTOR_SPEED,
	input wire logic [1:0] ACTIVE_MOTOR,
	input wire logic [11:0] SECOND_ANALOG_INPUT,
	// alarms and interrupt
	output logic MOTOR_OVERHEAT_ALARM,
	output logic SENSOR_OVERTEMP_ALARM,
	output logic IRQ
);
	thermal_pkg::prot_state_s st_q;
	thermal_pkg::prot_state_s st_d;
	thermal_pkg::mem_req_s mem_req;
	logic [31:0] mem_rdata;
	logic tick;
	logic step_now;
	logic sec_now;
	logic [15:0] tau_eff;
	logic [1:0] cmode;
	logic [9:0] icur;
	logic [9:0] trip_cur;
	logic [19:0] i2;
	logic [19:0] it2;
	logic signed [32:0] diff;
	logic signed [32:0] heat_sum;
	logic [31:0] heat_new;
	logic [19:0] pct_full;
	logic [9:0] pct_calc;
	logic trip_hit;
	logic [11:0] hyst_lvl;
	logic sens_hot;
	logic sens_cool;
	logic [32:0] wr_old;
	logic [31:0] wv;
	logic [32:0] rd;

	// trip current after speed derating for the selected mode
	function automatic logic [9:0] trip_level(input logic [1:0] mode, input logic [9:0] start,
		input logic [9:0] speed);
		logic [9:0] lvl;
		lvl = start;
		case (mode)
			2'h2: begin
				if (speed < `KNEE_LO) begin
					lvl = start - (start >> 4); // see [RQ4]
				end
			end
			2'h3: begin
				if (speed < `KNEE_LO) begin
					lvl = start - (start >> 2); // see [RQ4]
				end else if (speed < `KNEE_HI) begin
					lvl = start - (start >> 3); // see [RQ4]
				end
			end
			default: lvl = start; // see [RQ3]
		endcase
		return lvl;
	endfunction : trip_level

	// register read decode, top bit flags a mapped address
	function automatic logic [32:0] reg_word(input thermal_pkg::prot_state_s s,
		input logic [7:0] a);
		logic [32:0] r;
		r = {1'b1, 32'h00000000};
		case ({a[7:2], 2'b00})
			`OFS_CTRL: r[31:0] = {23'h000000, s.sens_en, 2'h0, s.mode[2], s.mode[1], s.mode[0]};
			`OFS_START: r[31:0] = {22'h000000, s.start_cur};
			`OFS_TAU: r[31:0] = {16'h0000, s.tau};
			`OFS_THRESH: r[31:0] = {20'h00000, s.thresh};
			`OFS_STATUS: r[31:0] = {28'h0000000, s.status};
			`OFS_MASK: r[31:0] = {28'h0000000, s.mask};
			`OFS_HEAT1: r[31:0] = {22'h000000, s.pct[0]}; // see [RQ10]
			`OFS_HEAT2: r[31:0] = {22'h000000, s.pct[1]};
			`OFS_HEAT3: r[31:0] = {22'h000000, s.pct[2]};
			default: r = 33'h000000000;
		endcase
		return r;
	endfunction : reg_word

	// byte-lane merge of write data into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	// fixed sample tick, model step and one-second pulse
	assign tick = (st_q.tick_cnt == SAMPLE_CYCLES - 16'h0001); // see [RQ15]
	assign tau_eff = (st_q.tau == 16'h0000) ? 16'h0001 : st_q.tau;
	assign step_now = tick && (st_q.step_cnt >= tau_eff - 16'h0001);
	assign sec_now = tick && (st_q.sec_cnt == 10'h3ff);

	// model arithmetic for the motor under update
	assign cmode = st_q.mode[st_q.idx];
	assign icur = (ACTIVE_MOTOR == st_q.idx) ? MOTOR_CURRENT : 10'h000; // see [RQ6]
	assign trip_cur = trip_level(cmode, st_q.start_cur, MOTOR_SPEED);
	assign i2 = {10'h000, icur} * {10'h000, icur};
	assign it2 = {10'h000, trip_cur} * {10'h000, trip_cur};
	assign diff = $signed({3'h0, i2, 10'h000}) - $signed({1'b0, mem_rdata}); // see [RQ7]
	assign heat_sum = $signed({1'b0, mem_rdata}) + (diff >>> `FRAC_BITS); // see [RQ7]
	assign heat_new = heat_sum[31:0];
	assign pct_full = heat_new[29:10] / `PCT_DIV; // see [RQ10]
	assign pct_calc = (pct_full > 20'h003ff) ? 10'h3ff : pct_full[9:0];
	assign trip_hit = (cmode != 2'h0) && (icur > trip_cur) // see [RQ13]
		&& (heat_new[29:10] >= it2); // see [RQ8]

	// sensor comparison with 5% hysteresis on release
	assign hyst_lvl = st_q.sens_trip - 12'(st_q.sens_trip / `HYST_DIV); // see [RQ12]
	assign sens_hot = st_q.sens_en && (SECOND_ANALOG_INPUT > st_q.thresh); // see [RQ11]
	assign sens_cool = (SECOND_ANALOG_INPUT <= hyst_lvl); // see [RQ12]

	// memory access, written only for motors with protection on
	assign mem_req = '{we: (st_q.seq == thermal_pkg::S_CALC) && (cmode != 2'h0), // see [RQ5]
		addr: st_q.idx, wdata: heat_new};

	heat_mem heat_mem_i (
		.clk(CORE_CLK),
		.rst_n(RESET_N),
		.req(mem_req),
		.rdata(mem_rdata)
	);

	// next state of the whole block
	always_comb begin
		st_d = st_q;
		wr_old = reg_word(st_q, st_q.awaddr);
		wv = merge(wr_old[31:0], st_q.wdata, st_q.wstrb);
		rd = reg_word(st_q, S_AXI_ARADDR);
		st_d.tick_cnt = tick ? 16'h0000 : st_q.tick_cnt + 16'h0001;
		if (tick) begin
			st_d.step_cnt = step_now ? 16'h0000 : st_q.step_cnt + 16'h0001;
			st_d.sec_cnt = st_q.sec_cnt + 10'h001;
		end
		// cooling timers count down in seconds
		for (int m = 0; m < 3; m++) begin
			if (sec_now && st_q.cool[m] != 16'h0000) begin
				st_d.cool[m] = st_q.cool[m] - 16'h0001; // see [RQ9]
			end
		end
		// write address and data are taken independently
		if (st_q.awready && S_AXI_AWVALID) begin
			st_d.awready = 1'b0;
			st_d.aw_full = 1'b1;
			st_d.awaddr = S_AXI_AWADDR;
		end
		if (st_q.wready && S_AXI_WVALID) begin
			st_d.wready = 1'b0;
			st_d.w_full = 1'b1;
			st_d.wdata = S_AXI_WDATA;
			st_d.wstrb = S_AXI_WSTRB;
		end
		// register write once both halves are held
		if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
			st_d.aw_full = 1'b0;
			st_d.w_full = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = wr_old[32] ? `RESP_OKAY : `RESP_SLVERR;
			case ({st_q.awaddr[7:2], 2'b00})
				`OFS_CTRL: begin
					st_d.mode[0] = wv[1:0]; // see [RQ1]
					st_d.mode[1] = wv[3:2];
					st_d.mode[2] = wv[5:4];
					st_d.sens_en = wv[`CTRL_SENS_BIT];
				end
				`OFS_START: st_d.start_cur = wv[9:0]; // see [RQ13]
				`OFS_TAU: st_d.tau = wv[15:0];
				`OFS_THRESH: st_d.thresh = wv[11:0];
				`OFS_STATUS: begin
					for (int m = 0; m < 3; m++) begin
						if (st_q.wdata[m] && st_q.wstrb[0] && st_q.cool[m] == 16'h0000) begin
							st_d.status[m] = 1'b0; // see [RQ9]
						end
					end
					if (st_q.wdata[`ST_SENS_BIT] && st_q.wstrb[0] && sens_cool) begin
						st_d.status[`ST_SENS_BIT] = 1'b0; // see [RQ12]
					end
				end
				`OFS_MASK: st_d.mask = wv[3:0];
				default: st_d.bvalid = 1'b1;
			endcase
		end
		if (st_q.bvalid && S_AXI_BREADY) begin
			st_d.bvalid = 1'b0;
			st_d.awready = 1'b1;
			st_d.wready = 1'b1;
		end
		// read channel, one outstanding read
		if (st_q.arready && S_AXI_ARVALID) begin
			st_d.arready = 1'b0;
			st_d.rvalid = 1'b1;
			st_d.rdata = rd[31:0];
			st_d.rresp = rd[32] ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (st_q.rvalid && S_AXI_RREADY) begin
			st_d.rvalid = 1'b0;
			st_d.arready = 1'b1;
		end
		// model sequencer walks the three motors each step
		case (st_q.seq)
			thermal_pkg::S_IDLE: begin
				if (step_now) begin
					st_d.idx = 2'h0;
					st_d.seq = thermal_pkg::S_READ;
				end
			end
			thermal_pkg::S_READ: st_d.seq = thermal_pkg::S_CALC;
			thermal_pkg::S_CALC: begin
				if (cmode != 2'h0) begin
					st_d.pct[st_q.idx] = pct_calc; // see [RQ10]
				end
				if (trip_hit) begin
					st_d.status[st_q.idx] = 1'b1; // see [RQ8] see [RQ2]
					// second boundary runs free, so one spare second keeps the full delay
					st_d.cool[st_q.idx] = (tau_eff == 16'hffff) ? tau_eff
						: tau_eff + 16'h0001; // see [RQ9]
				end
				if (st_q.idx == 2'h2) begin
					st_d.seq = thermal_pkg::S_IDLE;
				end else begin
					st_d.idx = st_q.idx + 2'h1; // see [RQ6]
					st_d.seq = thermal_pkg::S_READ;
				end
			end
			default: st_d.seq = thermal_pkg::S_IDLE;
		endcase
		// sensor alarm, set wins over a clear
		if (sens_hot) begin
			if (!st_q.status[`ST_SENS_BIT]) begin
				st_d.sens_trip = SECOND_ANALOG_INPUT;
			end
			st_d.status[`ST_SENS_BIT] = 1'b1; // see [RQ11]
		end
		// registered outputs
		st_d.irq = |(st_d.status & st_d.mask);
		st_d.ovh = |st_d.status[2:0];
		st_d.sen = st_d.status[`ST_SENS_BIT];
	end

	// state register with synchronous reset
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			st_q <= '0;
			st_q.awready <= 1'b1;
			st_q.wready <= 1'b1;
			st_q.arready <= 1'b1;
			st_q.mode <= {3{`RST_MODE}};
			st_q.start_cur <= `RST_START;
			st_q.tau <= `RST_TAU;
			st_q.thresh <= `RST_THRESH;
		end else begin
			st_q <= st_d;
		end
	end

	// port drive straight from state flops
	assign S_AXI_AWREADY = st_q.awready;
	assign S_AXI_WREADY = st_q.wready;
	assign S_AXI_BRESP = st_q.bresp;
	assign S_AXI_BVALID = st_q.bvalid;
	assign S_AXI_ARREADY = st_q.arready;
	assign S_AXI_RDATA = st_q.rdata;
	assign S_AXI_RRESP = st_q.rresp;
	assign S_AXI_RVALID = st_q.rvalid;
	assign MOTOR_OVERHEAT_ALARM = st_q.ovh;
	assign SENSOR_OVERTEMP_ALARM = st_q.sen;
	assign IRQ = st_q.irq;

	// checks on model, alarms and timebase
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);

	a_off_no_trip: assert property ( // see [RQ2]
		$rose(st_q.status[0]) |-> $past(st_q.mode[0]) != 2'h0)
		else $error("overheat alarm raised with protection off");

	a_flat_level: assert property ( // see [RQ3]
		cmode == 2'h1 |-> trip_cur == st_q.start_cur)
		else $error("mode 1 trip current was derated");

	a_shaft_derate: assert property ( // see [RQ4]
		(cmode == 2'h3) && (MOTOR_SPEED < 10'h019) && (st_q.start_cur >= 10'h004)
		|-> trip_cur < st_q.start_cur)
		else $error("mode 3 trip current not lowered at low speed");

	a_heat_rise: assert property ( // see [RQ7]
		mem_req.we && ({i2, 10'h000} > mem_rdata) |-> heat_new >= mem_rdata)
		else $error("heating fell while current square was above it");

	a_trip_cause: assert property ( // see [RQ13]
		$rose(st_q.status[1]) |-> $past(st_q.seq == thermal_pkg::S_CALC)
		&& $past(st_q.idx) == 2'h1 && $past(icur > trip_cur))
		else $error("overheat alarm without current above start level");

	a_cool_hold: assert property ( // see [RQ9]
		st_q.status[0] && st_q.cool[0] != 16'h0000 |=> st_q.status[0])
		else $error("overheat alarm cleared before cooling delay");

	a_pct_report: assert property ( // see [RQ10]
		mem_req.we |=> st_q.pct[$past(st_q.idx)] == $past(pct_calc))
		else $error("heating percentage not updated");

	a_sensor_trip: assert property ( // see [RQ11]
		sens_hot |=> st_q.status[3] && SENSOR_OVERTEMP_ALARM)
		else $error("sensor alarm missed an input above threshold");

	a_sensor_hyst: assert property ( // see [RQ12]
		$fell(st_q.status[3]) |-> $past(SECOND_ANALOG_INPUT) <= $past(hyst_lvl))
		else $error("sensor alarm cleared inside hysteresis band");

	a_tick_spacing: assert property ( // see [RQ15]
		tick |=> st_q.tick_cnt == 16'h0000 ##1 st_q.tick_cnt == 16'h0001)
		else $error("sample timebase did not restart");
endmodule : motor_thermal_protection
`default_nettype wire

// ---- sim/motor_model.sv ----
// Purpose: far-side motor and thermistor sensor for the protection bench
// Assumes: bench sets load and speed in percent and the sensor temperature code
// Notes: sensor voltage taken as proportional to winding temperature
`timescale 1ns/100ps
`default_nettype none
module motor_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// operating point set by the bench
	input wire logic [9:0] load_pct,
	input wire logic [9:0] speed_pct,
	input wire logic [11:0] temp_code,
	// measurements seen by the drive
	output logic [9:0] current,
	output logic [9:0] speed,
	output logic [11:0] sensor_volt
);
	// measurements follow the operating point one edge later
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			current <= 10'h000;
			speed <= 10'h000;
			sensor_volt <= 12'h000;
		end else begin
			current <= load_pct;
			speed <= speed_pct;
			sensor_volt <= temp_code; // rises with temperature
		end
	end
endmodule : motor_model
`default_nettype wire

// ---- sim/motor_thermal_protection_test.sv ----
// Purpose: self-checking bench for the motor thermal protection block
// Assumes: short sample interval and a one second time constant
// Notes: trip times come from the integer heating model below
`timescale 1ns/100ps
`default_nettype none
`include "thermal_map.svh"
module motor_thermal_protection_test;
	localparam int SC = 16;
	// clock, reset and register bus
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, ovh, sen, irq;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, v, h;
	logic [2:0] outs;
	// motor operating point
	logic [9:0] load = 10'h000;
	logic [9:0] spd = 10'h00a;
	logic [11:0] temp = 12'hfff;
	logic [1:0] act = 2'h0;
	logic [9:0] cur, mspd;
	logic [11:0] volt;
	int err_count = 0;
	int checks_done = 0;
	int c;
	logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
	logic [31:0] rv [7] = '{32'h3f, 32'h69, 32'h168, 32'h800, 32'h0, 32'h0, 32'h0};

	always #10 clk = ~clk;
	assign outs = {irq, sen, ovh};

	motor_thermal_protection #(.SAMPLE_CYCLES(16'(SC))) motor_thermal_protection_i (
		.CORE_CLK(clk), .RESET_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.MOTOR_CURRENT(cur), .MOTOR_SPEED(mspd), .ACTIVE_MOTOR(act),
		.SECOND_ANALOG_INPUT(volt), .MOTOR_OVERHEAT_ALARM(ovh),
		.SENSOR_OVERTEMP_ALARM(sen), .IRQ(irq)
	);
	motor_model motor_model_i (
		.clk(clk), .rst_n(rst_n), .load_pct(load), .speed_pct(spd), .temp_code(temp),
		.current(cur), .speed(mspd), .sensor_volt(volt)
	);

	// compare and report
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	// one write; address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		resp = bresp;
	endtask : wr

	// one read, data taken at the handshake edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		resp = rresp;
	endtask : rd

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		rd(a, v, r);
		chk(what, exp, v);
	endtask : rchk

	// cycles until one alarm or interrupt output reaches a level, bounded
	task automatic wait_out(input int b, input logic lvl, input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (outs[b] !== lvl && n < lim);
	endtask : wait_out

	// model steps until heating reaches the square of the trip level
	function automatic int steps(input longint i, input longint it);
		longint hh;
		int n;
		hh = 0;
		n = 0;
		while ((hh >> 10) < it * it) begin
			hh = hh + ((i * i * 1024 - hh) >> 10);
			n++;
		end
		return n;
	endfunction : steps

	// drive one motor at 200 percent and time its trip on the masked interrupt
	task automatic trip(input logic [1:0] m, input int it);
		int n;
		n = steps(200, it);
		wr(`OFS_MASK, 32'h1 << m, r);
		act <= m;
		load <= 10'd200;
		wait_out(2, 1'b1, (n + 4) * SC, c);
		chk("trip time", 32'h1, 32'(c > (n - 2) * SC && c <= (n + 4) * SC));
	endtask : trip

	task automatic test_done();
		$display("checks %0d, errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	// watchdog against a hung handshake
	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		test_done();
	end

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 7; k++)
			rchk("reset value", ra[k], rv[k]);
		chk("sensor alarm off", 32'h0, 32'(sen));
		rd(8'h24, v, r);
		chk("unmapped read", 32'(`RESP_SLVERR), 32'(r));
		wr(8'h24, 32'h1, r);
		chk("unmapped write", 32'(`RESP_SLVERR), 32'(r));
		temp <= 12'h000;
		wr(`OFS_TAU, 32'h1, r);
		wr(`OFS_CTRL, 32'h2c, r);
		load <= 10'd1000;
		repeat (60 * SC) @(posedge clk);
		chk("overheat in mode 0", 32'h0, 32'(ovh));
		rchk("heat in mode 0", `OFS_HEAT1, 32'h0);
		load <= 10'd0;
		wr(`OFS_CTRL, 32'h2d, r);
		trip(2'd0, 105);
		chk("overheat alarm", 32'h1, 32'(ovh));
		rd(`OFS_HEAT1, v, r);
		chk("heat percent", 32'h1, 32'(v >= 110 && v <= 112));
		rchk("other heat", `OFS_HEAT2, 32'h0);
		wr(`OFS_STATUS, 32'h1, r);
		rchk("early clear", `OFS_STATUS, 32'h1);
		trip(2'd1, 79);
		wr(`OFS_MASK, 32'h0, r);
		chk("masked irq", 32'h0, 32'(irq));
		chk("alarm under mask", 32'h1, 32'(ovh));
		trip(2'd2, 99);
		rchk("all tripped", `OFS_STATUS, 32'h7);
		load <= 10'd0;
		repeat (1000 * SC) @(posedge clk);
		wr(`OFS_STATUS, 32'h4, r);
		rchk("clear while cooling", `OFS_STATUS, 32'h7);
		// cooling may run up to two seconds past the last trip step
		repeat (1060 * SC) @(posedge clk);
		wr(`OFS_MASK, 32'hf, r);
		wr(`OFS_STATUS, 32'h7, r);
		rchk("cleared", `OFS_STATUS, 32'h0);
		chk("overheat cleared", 32'h0, 32'(ovh));
		chk("irq cleared", 32'h0, 32'(irq));
		wr(`OFS_THRESH, 32'h4ff, r);
		wr(`OFS_CTRL, 32'h100, r);
		temp <= 12'h500;
		wait_out(1, 1'b1, 4, c);
		chk("sensor trip", 32'h1, 32'(sen));
		chk("sensor irq", 32'h1, 32'(irq));
		temp <= 12'h4d0;
		wr(`OFS_STATUS, 32'h8, r);
		rchk("sensor hysteresis", `OFS_STATUS, 32'h8);
		temp <= 12'h4b0;
		wr(`OFS_STATUS, 32'h8, r);
		rchk("sensor cleared", `OFS_STATUS, 32'h0);
		rd(`OFS_HEAT1, h, r);
		wr(`OFS_HEAT1, 32'h0, r);
		chk("heat write resp", 32'(`RESP_OKAY), 32'(r));
		rchk("heat read only", `OFS_HEAT1, h);
		test_done();
	end
endmodule : motor_thermal_protection_test
`default_nettype wire
